/* File: adcrb_pkg.sv */
package adcrb_pkg;
	// Printed offsets are register indices; byte address is index times four
	localparam logic [3:0] IDX_CTRL_PRI   = 4'h0;
	localparam logic [3:0] IDX_CLK_DIV    = 4'h1;
	localparam logic [3:0] IDX_REF_CTRL   = 4'h2;
	localparam logic [3:0] IDX_EVT_CTRL   = 4'h3;
	localparam logic [3:0] IDX_IRQ_CLR    = 4'h4;
	localparam logic [3:0] IDX_IRQ_SET    = 4'h5;
	localparam logic [3:0] IDX_IRQ_FLAG   = 4'h6;
	localparam logic [3:0] IDX_DBG_CTRL   = 4'h7;
	localparam logic [3:0] IDX_SYNC_FLAGS = 4'h8;

	localparam int B_SOFT_RESET = 0;
	localparam int B_ENABLE     = 1;
	localparam int B_STANDBY    = 6;
	localparam int B_ON_DEMAND  = 7;
	localparam int B_REF_COMP   = 7;
	localparam int B_FLUSH_EI   = 0;
	localparam int B_START_EI   = 1;
	localparam int B_FLUSH_INV  = 2;
	localparam int B_START_INV  = 3;
	localparam int B_RES_EO     = 4;
	localparam int B_WIN_EO     = 5;
	localparam int B_IRQ_RES    = 0;
	localparam int B_IRQ_OVR    = 1;
	localparam int B_IRQ_WIN    = 2;
	localparam int B_DBG_RUN    = 0;
	localparam int B_SYNC_RST   = 0;
	localparam int B_SYNC_EN    = 1;

	localparam logic [7:0] CTRL_PRI_MASK = 8'hc3;
	localparam logic [7:0] CLK_DIV_MASK  = 8'h07;
	localparam logic [7:0] REF_CTRL_MASK = 8'h8f;
	localparam logic [7:0] EVT_CTRL_MASK = 8'h3f;
	localparam logic [7:0] IRQ_MASK      = 8'h07;
	localparam logic [7:0] DBG_MASK      = 8'h01;
	localparam logic [7:0] RESET_VALUE   = 8'h00;
	localparam logic [3:0] REF_SEL_LAST  = 4'h5;
	localparam logic [3:0] SYNC_DELAY    = 4'h4;

	typedef enum logic [3:0] {
		ADCRB_REF_INTERNAL_VAR = 4'h0,
		ADCRB_REF_SUPPLY_1P6   = 4'h1,
		ADCRB_REF_SUPPLY_HALF  = 4'h2,
		ADCRB_REF_EXT_A        = 4'h3,
		ADCRB_REF_EXT_B        = 4'h4,
		ADCRB_REF_FULL_SUPPLY  = 4'h5
	} adcrb_ref_t;

	typedef enum logic [1:0] {
		ADCRB_SYNC_IDLE,
		ADCRB_SYNC_ENABLE,
		ADCRB_SYNC_RESET
	} adcrb_sync_t;
endpackage : adcrb_pkg

/* File: adcrb_top.sv */
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module adcrb_top #(
	parameter int          ADDR_W     = 6,
	parameter logic [3:0]  SYNC_CYC   = adcrb_pkg::SYNC_DELAY
) (
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              standby_sleep,
	input  wire logic              periph_request,
	input  wire logic              start_event_in,
	input  wire logic              flush_event_in,
	input  wire logic              result_ready,
	input  wire logic              window_match,
	input  wire logic              overrun,
	output logic                   conv_start,
	output logic                   conv_flush,
	output logic                   result_event_out,
	output logic                   window_event_out,
	output logic                   adc_clk_en,
	output logic                   adc_running,
	output logic                   adc_enabled,
	output logic [3:0]             reference_select,
	output logic                   ref_buffer_offset_comp,
	output logic                   irq
);
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  clkdiv;
		logic [7:0]  refc;
		logic [7:0]  evc;
		logic [7:0]  ien;
		logic [7:0]  iflag;
		logic [7:0]  dbg;
		logic        en_applied;
		logic [3:0]  sync_cnt;
		adcrb_pkg::adcrb_sync_t sync_st;
		logic [7:0]  presc;
		logic        start_prev;
		logic        flush_prev;
		logic        conv_start;
		logic        conv_flush;
		logic        res_eo;
		logic        win_eo;
		logic        clk_en;
		logic        ack;
		logic [31:0] rdata;
	} adcrb_state_t;

	adcrb_state_t s_q;
	adcrb_state_t s_d;

	function automatic logic [7:0] adcrb_merge(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] mask);
		adcrb_merge = (old & ~mask) | (wd & mask);
	endfunction : adcrb_merge

	logic [3:0] idx;
	logic       sel_ok;
	logic       wr;
	logic       rd;
	logic [7:0] wd;
	logic       start_lvl;
	logic       flush_lvl;
	logic       run;

	always_comb begin
		idx       = avs_address[5:2];
		sel_ok    = (avs_address[ADDR_W-1:2] <= {{(ADDR_W-6){1'b0}}, adcrb_pkg::IDX_SYNC_FLAGS});
		wr        = avs_write && !s_q.ack && avs_byteenable[0];
		rd        = avs_read && !s_q.ack;
		wd        = avs_writedata[7:0];
		start_lvl = start_event_in ^ s_q.evc[adcrb_pkg::B_START_INV];
		flush_lvl = flush_event_in ^ s_q.evc[adcrb_pkg::B_FLUSH_INV];
		// Standby gating is applied directly, no synchronizer in the path
		run = s_q.en_applied
			&& !(standby_sleep && !s_q.ctrl[adcrb_pkg::B_STANDBY])
			&& (!s_q.ctrl[adcrb_pkg::B_ON_DEMAND] || periph_request);
	end

	always_comb begin
		s_d            = s_q;
		s_d.ack        = (avs_read || avs_write) && !s_q.ack;
		s_d.rdata      = 32'h0000_0000;
		s_d.conv_start = 1'b0;
		s_d.conv_flush = 1'b0;
		s_d.res_eo     = s_q.evc[adcrb_pkg::B_RES_EO] && result_ready;
		s_d.win_eo     = s_q.evc[adcrb_pkg::B_WIN_EO] && window_match;
		s_d.start_prev = start_lvl;
		s_d.flush_prev = flush_lvl;
		if (run && s_q.evc[adcrb_pkg::B_START_EI] && start_lvl && !s_q.start_prev) begin
			s_d.conv_start = 1'b1;
		end
		if (run && s_q.evc[adcrb_pkg::B_FLUSH_EI] && flush_lvl && !s_q.flush_prev) begin
			s_d.conv_flush = 1'b1;
			s_d.conv_start = 1'b1;
		end
		// Prescaler counts only while running to save power
		s_d.presc  = run ? s_q.presc + 8'h01 : 8'h00;
		s_d.clk_en = 1'b0;
		if (run) begin
			s_d.clk_en = ((s_q.presc + 8'h01) & ((8'h02 << s_q.clkdiv[2:0]) - 8'h01)) == 8'h00;
		end
		// Flags: hardware set wins over software clear
		if (wr && sel_ok && idx == adcrb_pkg::IDX_IRQ_FLAG) begin
			s_d.iflag = s_q.iflag & ~(wd & adcrb_pkg::IRQ_MASK);
		end
		s_d.iflag[adcrb_pkg::B_IRQ_RES] = s_d.iflag[adcrb_pkg::B_IRQ_RES] | result_ready;
		s_d.iflag[adcrb_pkg::B_IRQ_OVR] = s_d.iflag[adcrb_pkg::B_IRQ_OVR] | overrun;
		s_d.iflag[adcrb_pkg::B_IRQ_WIN] = s_d.iflag[adcrb_pkg::B_IRQ_WIN] | window_match;
		case (s_q.sync_st)
			adcrb_pkg::ADCRB_SYNC_ENABLE: begin
				s_d.sync_cnt = s_q.sync_cnt - 4'h1;
				if (s_q.sync_cnt == 4'h1) begin
					s_d.en_applied = s_q.ctrl[adcrb_pkg::B_ENABLE];
					s_d.sync_st    = adcrb_pkg::ADCRB_SYNC_IDLE;
				end
			end
			adcrb_pkg::ADCRB_SYNC_RESET: begin
				s_d.sync_cnt = s_q.sync_cnt - 4'h1;
				if (s_q.sync_cnt == 4'h1) begin
					s_d.ctrl    = adcrb_pkg::RESET_VALUE;
					s_d.sync_st = adcrb_pkg::ADCRB_SYNC_IDLE;
				end
			end
			default: begin
			end
		endcase
		if (wr && sel_ok) begin
			case (idx)
				adcrb_pkg::IDX_CTRL_PRI: begin
					if (wd[adcrb_pkg::B_SOFT_RESET]) begin
						s_d.ctrl       = 8'h01;
						s_d.clkdiv     = adcrb_pkg::RESET_VALUE;
						s_d.refc       = adcrb_pkg::RESET_VALUE;
						s_d.evc        = adcrb_pkg::RESET_VALUE;
						s_d.ien        = adcrb_pkg::RESET_VALUE;
						s_d.iflag      = adcrb_pkg::RESET_VALUE;
						s_d.en_applied = 1'b0;
						s_d.sync_cnt   = SYNC_CYC;
						s_d.sync_st    = adcrb_pkg::ADCRB_SYNC_RESET;
					end else if (s_q.sync_st != adcrb_pkg::ADCRB_SYNC_RESET) begin
						s_d.ctrl = adcrb_merge(s_q.ctrl, wd, adcrb_pkg::CTRL_PRI_MASK);
						if (wd[adcrb_pkg::B_ENABLE] != s_q.ctrl[adcrb_pkg::B_ENABLE]) begin
							s_d.sync_cnt = SYNC_CYC;
							s_d.sync_st  = adcrb_pkg::ADCRB_SYNC_ENABLE;
						end
					end
				end
				adcrb_pkg::IDX_CLK_DIV: begin
					if (!s_q.ctrl[adcrb_pkg::B_ENABLE]) begin
						s_d.clkdiv = wd & adcrb_pkg::CLK_DIV_MASK;
					end
				end
				adcrb_pkg::IDX_REF_CTRL: begin
					if (!s_q.ctrl[adcrb_pkg::B_ENABLE]) begin
						s_d.refc = wd & adcrb_pkg::REF_CTRL_MASK;
					end
				end
				adcrb_pkg::IDX_EVT_CTRL: begin
					if (!s_q.ctrl[adcrb_pkg::B_ENABLE]) begin
						s_d.evc = wd & adcrb_pkg::EVT_CTRL_MASK;
					end
				end
				adcrb_pkg::IDX_IRQ_CLR: s_d.ien = s_q.ien & ~(wd & adcrb_pkg::IRQ_MASK);
				adcrb_pkg::IDX_IRQ_SET: s_d.ien = s_q.ien | (wd & adcrb_pkg::IRQ_MASK);
				adcrb_pkg::IDX_DBG_CTRL: s_d.dbg = wd & adcrb_pkg::DBG_MASK;
				default: begin
				end
			endcase
		end
		if (rd && sel_ok) begin
			case (idx)
				adcrb_pkg::IDX_CTRL_PRI: s_d.rdata[7:0] = s_q.ctrl;
				adcrb_pkg::IDX_CLK_DIV:  s_d.rdata[7:0] = s_q.clkdiv;
				adcrb_pkg::IDX_REF_CTRL: s_d.rdata[7:0] = s_q.refc;
				adcrb_pkg::IDX_EVT_CTRL: s_d.rdata[7:0] = s_q.evc;
				adcrb_pkg::IDX_IRQ_CLR:  s_d.rdata[7:0] = s_q.ien;
				adcrb_pkg::IDX_IRQ_SET:  s_d.rdata[7:0] = s_q.ien;
				adcrb_pkg::IDX_IRQ_FLAG: s_d.rdata[7:0] = s_q.iflag;
				adcrb_pkg::IDX_DBG_CTRL: s_d.rdata[7:0] = s_q.dbg;
				adcrb_pkg::IDX_SYNC_FLAGS: begin
					s_d.rdata[adcrb_pkg::B_SYNC_RST] = (s_q.sync_st == adcrb_pkg::ADCRB_SYNC_RESET);
					s_d.rdata[adcrb_pkg::B_SYNC_EN]  = (s_q.sync_st == adcrb_pkg::ADCRB_SYNC_ENABLE);
				end
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		avs_waitrequest        = (avs_read || avs_write) && !s_q.ack;
		avs_readdata           = s_q.rdata;
		conv_start             = s_q.conv_start;
		conv_flush             = s_q.conv_flush;
		result_event_out       = s_q.res_eo;
		window_event_out       = s_q.win_eo;
		adc_clk_en             = s_q.clk_en;
		adc_running            = run;
		adc_enabled            = s_q.en_applied;
		reference_select       = s_q.refc[3:0];
		ref_buffer_offset_comp = s_q.refc[adcrb_pkg::B_REF_COMP];
		irq = |(s_q.ien & s_q.iflag & adcrb_pkg::IRQ_MASK);
	end
endmodule : adcrb_top

/* File: adcrb_chk.sv */
`timescale 1ns/1ps
module adcrb_chk #(
	parameter int         ADDR_W   = 6,
	parameter logic [3:0] SYNC_CYC = 4'h4
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic result_ready,
	input wire logic window_match,
	input wire logic overrun,
	input wire logic conv_start,
	input wire logic conv_flush,
	input wire logic result_event_out,
	input wire logic window_event_out,
	input wire logic adc_clk_en,
	input wire logic adc_running,
	input wire logic adc_enabled,
	input wire logic irq
);
	default clocking dcb @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest;
	endsequence
	AST_ONE_WAIT: assert property (s_req_wait |=> s_ack)
		else $error("Bus answer late");
	AST_RUN_NEEDS_EN: assert property (adc_running |-> adc_enabled)
		else $error("Running while not enabled");
	AST_CLK_GAP: assert property (adc_clk_en |=> !adc_clk_en)
		else $error("Converter clock faster than half");
	AST_FLUSH_STARTS: assert property (conv_flush |-> conv_start)
		else $error("Flush without new start");
	AST_FLUSH_ONE: assert property (conv_flush |=> !conv_flush)
		else $error("Flush pulse too long");
	AST_RES_EVENT: assert property (result_event_out |-> $past(result_ready))
		else $error("Result event without cause");
	AST_WIN_EVENT: assert property (window_event_out |-> $past(window_match))
		else $error("Window event without cause");
	// A write to the set register may also raise irq for an already pending flag
	AST_IRQ_CAUSE: assert property ($rose(irq) |->
		$past(window_match || result_ready || overrun || avs_write))
		else $error("Interrupt without cause");
endmodule : adcrb_chk

/* File: adcrb_evnet.sv */
`timescale 1ns/1ps
module adcrb_evnet (
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic [6:0] cmd,
	output logic [6:0]      ev_q
);
	// Registered so every line moves just after an edge
	always_ff @(posedge clk_sys) begin
		if (srst) ev_q <= 7'h00;
		else ev_q <= cmd;
	end
endmodule : adcrb_evnet

/* File: adc_control_register_bank_tb.sv */
`timescale 1ns/1ps
module adc_control_register_bank_tb;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [6:0]  cmd = 7'h00;
	logic [6:0]  ev;
	logic [3:0]  seen, ref_sel, i4;
	logic [7:0]  q, d;
	logic        cst, cfl, reo, weo, cen, run, ena, comp, irq;
	int          errors = 0;
	int          n_tests = 0;
	int          seed = 32'ha05c;
	int          n;
	always #2 clk_sys = ~clk_sys;
	adcrb_evnet net_u (.clk_sys(clk_sys), .srst(srst), .cmd(cmd), .ev_q(ev));
	adcrb_top dut_u (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.standby_sleep(ev[0]), .periph_request(ev[1]), .start_event_in(ev[2]),
		.flush_event_in(ev[3]), .result_ready(ev[4]), .window_match(ev[5]), .overrun(ev[6]),
		.conv_start(cst), .conv_flush(cfl), .result_event_out(reo), .window_event_out(weo),
		.adc_clk_en(cen), .adc_running(run), .adc_enabled(ena), .reference_select(ref_sel),
		.ref_buffer_offset_comp(comp), .irq(irq));
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg
	// Callers sample pins at a falling edge, where registered outputs have settled
	task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_pin
	function automatic logic [7:0] msk(input logic [3:0] i, input logic [7:0] v);
		case (i)
			4'h1: return v & adcrb_pkg::CLK_DIV_MASK;
			4'h2: return v & adcrb_pkg::REF_CTRL_MASK;
			default: return v & adcrb_pkg::EVT_CTRL_MASK;
		endcase
	endfunction : msk
	task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge clk_sys);
		avs_address <= {i, 2'b00};
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= {24'h0, wd};
		do begin
			@(posedge clk_sys);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 40);
		if (k >= 40) begin
			errors++;
			wrap_up();
		end
		// Read data and release both belong to the edge that sees waitrequest low
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(negedge clk_sys);
	endtask : bus
	task automatic poll();
		int k;
		k = 0;
		do begin
			bus(1'b0, 4'h8, 8'h00);
			k++;
		end while (q !== 8'h00 && k < 40);
		chk_reg("sync", 8'h00, q);
	endtask : poll
	task automatic pulse(input int b, input logic [3:0] e);
		@(posedge clk_sys);
		cmd[b] <= 1'b1;
		@(posedge clk_sys);
		cmd[b] <= 1'b0;
		seen = 4'h0;
		repeat (6) begin
			@(negedge clk_sys);
			seen |= {weo, reo, cfl, cst};
		end
		chk_pin("events", {12'h0, e}, {12'h0, seen});
	endtask : pulse
	// Far beyond the fewer than a thousand cycles the sequence needs
	initial begin
		#160000;
		errors++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		for (int i = 1; i < 5; i++) begin
			bus(1'b0, 4'(i), 8'h00);
			chk_reg("reset value", 8'h00, q);
		end
		bus(1'b1, 4'h9, 8'hff);
		bus(1'b0, 4'h9, 8'h00);
		chk_reg("unmapped", 8'h00, q);
		repeat (6) begin
			i4 = 4'h1 + 4'($unsigned($random(seed)) % 3);
			d = 8'($random(seed));
			bus(1'b1, i4, d);
			bus(1'b0, i4, 8'h00);
			chk_reg("masked rw", msk(i4, d), q);
		end
		for (int r = 0; r < 6; r++) begin
			d = {r[0], 3'b000, 4'(r)};
			bus(1'b1, 4'h2, d);
			chk_pin("ref", {11'h0, d[7], d[3:0]}, {11'h0, comp, ref_sel});
		end
		bus(1'b1, 4'h1, 8'h07);
		bus(1'b1, 4'h3, 8'h33);
		bus(1'b1, 4'h7, 8'h01);
		bus(1'b1, 4'h0, 8'h02);
		bus(1'b0, 4'h8, 8'h00);
		chk_reg("enable busy", 8'h02, q);
		bus(1'b0, 4'h0, 8'h00);
		chk_reg("enable readback", 8'h02, q);
		poll();
		chk_pin("enabled", 16'h1, {15'h0, ena});
		bus(1'b1, 4'h1, 8'h00);
		bus(1'b0, 4'h1, 8'h00);
		chk_reg("protected", 8'h07, q);
		do @(negedge clk_sys); while (cen !== 1'b1);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (cen !== 1'b1 && n < 600);
		chk_pin("period", 16'h2 << 7, 16'(n));
		pulse(2, 4'h1);
		pulse(3, 4'h3);
		pulse(4, 4'h4);
		bus(1'b1, 4'h5, 8'h04);
		pulse(5, 4'h8);
		chk_pin("irq", 16'h1, {15'h0, irq});
		bus(1'b0, 4'h4, 8'h00);
		chk_reg("clear mirror", 8'h04, q);
		bus(1'b1, 4'h4, 8'h04);
		bus(1'b0, 4'h5, 8'h00);
		chk_reg("set mirror", 8'h00, q);
		chk_pin("irq off", 16'h0, {15'h0, irq});
		@(posedge clk_sys);
		cmd[0] <= 1'b1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_pin("halt", 16'h0, {15'h0, run});
		bus(1'b1, 4'h0, 8'h42);
		chk_pin("standby run", 16'h1, {15'h0, run});
		bus(1'b1, 4'h0, 8'hc2);
		chk_pin("no request", 16'h0, {15'h0, run});
		@(posedge clk_sys);
		cmd[1] <= 1'b1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_pin("on request", 16'h1, {15'h0, run});
		bus(1'b1, 4'h0, 8'hc3);
		bus(1'b0, 4'h0, 8'h00);
		chk_reg("reset pending", 8'h01, q);
		poll();
		bus(1'b0, 4'h0, 8'h00);
		chk_reg("reset done", 8'h00, q);
		bus(1'b0, 4'h1, 8'h00);
		chk_reg("divider reset", 8'h00, q);
		bus(1'b0, 4'h7, 8'h00);
		chk_reg("debug kept", 8'h01, q);
		chk_pin("disabled", 16'h0, {15'h0, ena});
		wrap_up();
	end
endmodule : adc_control_register_bank_tb
bind adcrb_top adcrb_chk #(.ADDR_W(ADDR_W), .SYNC_CYC(SYNC_CYC)) chk_u (.*);
